// ### rcst_pkg.sv
// Package with register map, field layout and timing constants of the state tracker
package rcst_pkg;
  // Register byte offsets
  localparam logic [7:0] ADDR_CTRL      = 8'h00;
  localparam logic [7:0] ADDR_DSG_THR   = 8'h04;
  localparam logic [7:0] ADDR_CHG_THR   = 8'h08;
  localparam logic [7:0] ADDR_QUIT_CUR  = 8'h0c;
  localparam logic [7:0] ADDR_DSG_RELAX = 8'h10;
  localparam logic [7:0] ADDR_CHG_RELAX = 8'h14;
  localparam logic [7:0] ADDR_RESERVE   = 8'h18;
  localparam logic [7:0] ADDR_QCELL0    = 8'h1c;
  localparam logic [7:0] ADDR_QPACK     = 8'h2c;
  localparam logic [7:0] ADDR_LEARN     = 8'h30;
  localparam logic [7:0] ADDR_MFG_CMD   = 8'h34;
  localparam logic [7:0] ADDR_STATUS    = 8'h38;
  localparam logic [7:0] ADDR_AVG_I     = 8'h3c;
  localparam logic [7:0] ADDR_AVG_P     = 8'h40;
  localparam logic [7:0] ADDR_SAG       = 8'h44;
  localparam logic [7:0] ADDR_RES_EFF   = 8'h48;
  localparam logic [7:0] ADDR_SAG_PCT   = 8'h4c;
  localparam logic [7:0] ADDR_DVDT_LIM  = 8'h50;
  // Control bit positions
  localparam int CTRL_CAPACITY_UNIT_MODE   = 0;
  localparam int CTRL_RESCMP = 1;
  // Learn status word
  localparam logic [7:0] LEARN_QMAX_BIT = 8'h02;
  localparam logic [7:0] LEARN_EN_BIT   = 8'h04;
  localparam logic [7:0] LEARN_MASK     = 8'h06;
  localparam logic [15:0] MFG_GAUGE_EN  = 16'h0021;
  // Status bit positions
  localparam int ST_DSG_FLAG = 0;
  localparam int ST_IS_DSG   = 1;
  localparam int ST_IS_CHG   = 2;
  localparam int ST_RELAX    = 3;
  localparam int ST_OCV_REQ  = 4;
  localparam int ST_QMAX_OK  = 5;
  // Reset values (mA, s, uV/s, percent)
  localparam logic [15:0] DSG_THR_RST   = 16'h0064;
  localparam logic [15:0] CHG_THR_RST   = 16'h0064;
  localparam logic [15:0] QUIT_RST      = 16'h000a;
  localparam logic [15:0] RELAX_RST     = 16'h003c;
  localparam logic [15:0] RESERVE_RST   = 16'h0000;
  localparam logic [15:0] QCELL_RST     = 16'h0fa0;
  localparam logic [7:0]  SAG_PCT_RST   = 8'h32;
  localparam logic [15:0] DVDT_LIM_RST  = 16'h0004;
  // Timing
  localparam int CLK_HZ       = 50_000_000;
  localparam int OCV_WAIT_S   = 1800;
  localparam int SAG_AVG_LOG2 = 3;
  // Tracker states, Gray along the usual path
  typedef enum logic [1:0] {
    RCST_FLOW  = 2'b00,
    RCST_TIMER = 2'b01,
    RCST_RELAX = 2'b11,
    RCST_OCV   = 2'b10
  } rcst_state_e;
endpackage

// ### rcst_tracker.sv
// Relaxation and capacity state tracker with APB register access
//
// Added by the designer: register access over APB and the placing of the registers.
`timescale 1ns/10ps
// Behaviour
// - Reserve compensation select 0 gives no-load, 1 gives load-compensated reserve.
// - Reserve energy is used only in power-based capacity mode.
// - Reserve energy resets to zero; zero disables the reserve function only while compensation select is 0.
// - Discharging flag clear while charging, set otherwise including zero current.
// - Actual discharge only when magnitude exceeds discharge threshold, default 100 mA.
// - Actual charge only when current exceeds the charge threshold.
// - Leaving below minus quit current into band starts discharge relax timer.
// - Leaving above plus quit current into band starts charge relax timer.
// - Relaxation entered only if current stays in band until timer expiry.
// - After about 30 minutes relaxed, request open-circuit voltage readings.
// - Maximum-capacity update only when voltage slope below 4 uV per second.
// - Pack capacity tracks the lowest of four cell capacities.
// - Learn bit 1 set by hardware on new capacity; software may write it.
// - Learn bit 2 enables gauging, set by command 0x0021; others reserved.
// - Average current per discharge cycle kept as previous-cycle value.
// - Power is current times voltage, averaged per cycle, previous stored.
// - Sag is short average voltage minus instant voltage, maximum tracked.
// - Peak sag updated only when a new value is larger.
// - At each grid point peak sag reloads a percentage of previous peak.
module rcst_tracker
  import rcst_pkg::*;
#(
  parameter int OCV_WAIT_CYCLES = OCV_WAIT_S * 1,
  parameter int SEC_CYCLES      = CLK_HZ
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        clk_en,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        sample_valid,
  input  wire logic [15:0] sample_current,
  input  wire logic [15:0] sample_voltage,
  input  wire logic        soc_grid_point,
  input  wire logic        cell_qmax_valid,
  input  wire logic [1:0]  cell_qmax_index,
  input  wire logic [15:0] cell_qmax_value,
  output logic             dsg_flag,
  output logic             relax_mode,
  output logic             ocv_request,
  output logic             qmax_update
);
  // ==========================================================
  // Helpers
  function automatic logic signed [16:0] sx(input logic [15:0] v);
    sx = {v[15], v};
  endfunction
  function automatic logic [15:0] umin(input logic [15:0] a, input logic [15:0] b);
    umin = (a < b) ? a : b;
  endfunction

  // ==========================================================
  // Registers
  logic [1:0]  ctrl;
  logic [15:0] dsg_thr, chg_thr, quit_cur, dsg_relax_s, chg_relax_s, reserve_energy;
  logic [15:0] qcell [4];
  logic [15:0] qpack;
  logic [7:0]  learn_status_word;
  logic [7:0]  sag_pct;
  logic [15:0] dvdt_lim;
  logic [15:0] avg_i_last;
  logic [31:0] avg_p_last;
  logic [15:0] peak_sag;

  wire wr_en = psel & penable & pwrite & clk_en;
  wire rd_acc = psel & ~pwrite;
  wire [7:0] a = paddr;
  wire is_qcell = (a >= ADDR_QCELL0) && (a < ADDR_QPACK) && (a[1:0] == 2'b00);
  wire [1:0] qidx = 2'((a - ADDR_QCELL0) >> 2);
  wire mapped = is_qcell || a == ADDR_CTRL || a == ADDR_DSG_THR || a == ADDR_CHG_THR ||
                a == ADDR_QUIT_CUR || a == ADDR_DSG_RELAX || a == ADDR_CHG_RELAX ||
                a == ADDR_RESERVE || a == ADDR_QPACK || a == ADDR_LEARN || a == ADDR_MFG_CMD ||
                a == ADDR_STATUS || a == ADDR_AVG_I || a == ADDR_AVG_P || a == ADDR_SAG ||
                a == ADDR_RES_EFF || a == ADDR_SAG_PCT || a == ADDR_DVDT_LIM;
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~mapped;

  // ==========================================================
  // Input sync (front end is asynchronous)
  logic        v_s1, v_s2, v_s3, g_s1, g_s2, g_s3;
  logic [15:0] i_s1, i_s2, u_s1, u_s2;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {v_s1, v_s2, v_s3, g_s1, g_s2, g_s3} <= '0;
      {i_s1, i_s2, u_s1, u_s2} <= '0;
    end else if (clk_en) begin
      v_s1 <= sample_valid;
      v_s2 <= v_s1;
      v_s3 <= v_s2;
      g_s1 <= soc_grid_point;
      g_s2 <= g_s1;
      g_s3 <= g_s2;
      i_s1 <= sample_current;
      i_s2 <= i_s1;
      u_s1 <= sample_voltage;
      u_s2 <= u_s1;
    end
  end
  wire samp = v_s2 & ~v_s3;
  wire grid = g_s2 & ~g_s3;
  // Hold each sample; the bus between strobes is not trustworthy
  logic [15:0] i_hold, u_hold;
  logic        samp_d;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      i_hold <= '0;
      u_hold <= '0;
      samp_d <= 1'b0;
    end else if (clk_en) begin
      samp_d <= samp;
      if (samp) begin
        i_hold <= i_s2;
        u_hold <= u_s2;
      end
    end
  end
  wire signed [16:0] cur = sx(i_hold);

  // ==========================================================
  // Current classification
  wire signed [16:0] quit_p = {1'b0, quit_cur};
  wire signed [16:0] quit_n = -quit_p;
  wire above_band = cur > quit_p;
  wire below_band = cur < quit_n;
  wire in_band    = ~above_band & ~below_band;
  wire charging   = cur > 17'sd0;
  assign dsg_flag = ~charging;
  wire is_dsg = cur < -$signed({1'b0, dsg_thr});
  wire is_chg = cur > $signed({1'b0, chg_thr});

  // ==========================================================
  // Relax state machine
  rcst_state_e state, next_state;
  logic        last_dir_chg, timer_chg, seen_out;
  logic [31:0] sec_cnt, secs, next_secs;
  wire tick = (sec_cnt == 32'(SEC_CYCLES - 1));
  wire [15:0] relax_lim = timer_chg ? chg_relax_s : dsg_relax_s;
  wire gauge_en = learn_status_word[2];
  always_comb begin
    next_state = state;
    next_secs  = tick ? secs + 32'd1 : secs;
    unique case (state)
      RCST_FLOW: begin
        next_secs = '0;
        if (in_band && gauge_en && seen_out) next_state = RCST_TIMER;
      end
      RCST_TIMER: begin
        if (!in_band) next_state = RCST_FLOW;
        else if (secs >= 32'(relax_lim)) begin
          next_state = RCST_RELAX;
          next_secs  = '0;
        end
      end
      RCST_RELAX: begin
        if (!in_band) next_state = RCST_FLOW;
        else if (secs >= 32'(OCV_WAIT_CYCLES)) next_state = RCST_OCV;
      end
      RCST_OCV: if (!in_band) next_state = RCST_FLOW;
    endcase
  end
  assign relax_mode  = (state == RCST_RELAX) || (state == RCST_OCV);
  assign ocv_request = (state == RCST_OCV);

  // Voltage slope in uV per second, 1 mV sample units
  logic [15:0] v_at_sec;
  logic [31:0] dvdt;
  wire [15:0] dv = (u_hold > v_at_sec) ? u_hold - v_at_sec : v_at_sec - u_hold;
  wire dvdt_ok = (dvdt < 32'(dvdt_lim)) && ocv_request;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= RCST_FLOW;
      sec_cnt <= '0;
      secs <= '0;
      last_dir_chg <= 1'b0;
      seen_out <= 1'b0;
      timer_chg <= 1'b0;
      v_at_sec <= '0;
      dvdt <= 32'hffffffff;
      qmax_update <= 1'b0;
    end else if (clk_en) begin
      state <= next_state;
      secs <= next_secs;
      sec_cnt <= (tick || state == RCST_FLOW) ? '0 : sec_cnt + 32'd1;
      if (above_band) last_dir_chg <= 1'b1;
      else if (below_band) last_dir_chg <= 1'b0;
      if (state == RCST_FLOW) timer_chg <= last_dir_chg;
      // Timer needs a prior excursion out of the band
      if (!in_band) seen_out <= 1'b1;
      else if (state == RCST_TIMER) seen_out <= 1'b0;
      if (tick) begin
        v_at_sec <= u_hold;
        dvdt <= 32'(dv) * 32'd1000;
      end
      qmax_update <= dvdt_ok & tick;
    end
  end

  // ==========================================================
  // Discharge cycle averages
  logic        in_cycle;
  logic signed [47:0] sum_i;
  logic [63:0] sum_p;
  logic [31:0] n_samp;
  wire [15:0] mag_i = 16'(-cur);
  wire [31:0] pwr = 32'(mag_i) * 32'(u_hold);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_cycle <= 1'b0;
      sum_i <= '0;
      sum_p <= '0;
      n_samp <= '0;
      avg_i_last <= '0;
      avg_p_last <= '0;
    end else if (clk_en && samp_d) begin
      if (is_dsg) begin
        in_cycle <= 1'b1;
        sum_i <= sum_i + 48'(mag_i);
        sum_p <= sum_p + 64'(pwr);
        n_samp <= n_samp + 32'd1;
      end else if (in_cycle) begin
        in_cycle <= 1'b0;
        avg_i_last <= 16'(sum_i / 48'(n_samp));
        avg_p_last <= 32'(sum_p / 64'(n_samp));
        sum_i <= '0;
        sum_p <= '0;
        n_samp <= '0;
      end
    end
  end

  // ==========================================================
  // Voltage sag
  logic [15:0] v_avg;
  wire [15:0] sag = (v_avg > u_hold) ? v_avg - u_hold : 16'h0000;
  wire [15:0] sag_reload = 16'((32'(peak_sag) * 32'(sag_pct)) / 32'd100);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      v_avg <= '0;
      peak_sag <= '0;
    end else if (clk_en) begin
      if (samp_d) v_avg <= 16'(v_avg - (v_avg >> SAG_AVG_LOG2) + (u_hold >> SAG_AVG_LOG2));
      if (grid) peak_sag <= sag_reload;
      else if (samp_d && sag > peak_sag) peak_sag <= sag;
    end
  end

  // ==========================================================
  // Reserve energy effect
  wire [15:0] reserve_eff = ctrl[CTRL_CAPACITY_UNIT_MODE] ? reserve_energy : 16'h0000;
  wire [15:0] reserve_comp = ctrl[CTRL_RESCMP] ? 16'(reserve_eff + avg_p_last[15:0]) : reserve_eff;

  // ==========================================================
  // Register writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= '0;
      dsg_thr <= DSG_THR_RST;
      chg_thr <= CHG_THR_RST;
      quit_cur <= QUIT_RST;
      dsg_relax_s <= RELAX_RST;
      chg_relax_s <= RELAX_RST;
      reserve_energy <= RESERVE_RST;
      sag_pct <= SAG_PCT_RST;
      dvdt_lim <= DVDT_LIM_RST;
      learn_status_word <= '0;
      for (int k = 0; k < 4; k++) qcell[k] <= QCELL_RST;
    end else if (clk_en) begin
      if (wr_en && a == ADDR_CTRL) ctrl <= pwdata[1:0];
      if (wr_en && a == ADDR_DSG_THR) dsg_thr <= pwdata[15:0];
      if (wr_en && a == ADDR_CHG_THR) chg_thr <= pwdata[15:0];
      if (wr_en && a == ADDR_QUIT_CUR) quit_cur <= pwdata[15:0];
      if (wr_en && a == ADDR_DSG_RELAX) dsg_relax_s <= pwdata[15:0];
      if (wr_en && a == ADDR_CHG_RELAX) chg_relax_s <= pwdata[15:0];
      if (wr_en && a == ADDR_RESERVE) reserve_energy <= pwdata[15:0];
      if (wr_en && a == ADDR_SAG_PCT) sag_pct <= pwdata[7:0];
      if (wr_en && a == ADDR_DVDT_LIM) dvdt_lim <= pwdata[15:0];
      if (wr_en && is_qcell) qcell[qidx] <= pwdata[15:0];
      if (cell_qmax_valid && qmax_update) qcell[cell_qmax_index] <= cell_qmax_value;
      // Hardware set wins over software clear
      if (wr_en && a == ADDR_LEARN) learn_status_word <= pwdata[7:0] & LEARN_MASK;
      if (wr_en && a == ADDR_MFG_CMD && pwdata[15:0] == MFG_GAUGE_EN)
        learn_status_word[2] <= 1'b1;
      if (cell_qmax_valid && qmax_update) learn_status_word[1] <= 1'b1;
    end
  end
  // Pack capacity follows weakest cell
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) qpack <= QCELL_RST;
    else if (clk_en) qpack <= umin(umin(qcell[0], qcell[1]), umin(qcell[2], qcell[3]));
  end

  // ==========================================================
  // Read mux
  logic [31:0] rd;
  always_comb begin
    rd = '0;
    if (is_qcell) rd = {16'h0000, qcell[qidx]};
    else
      unique case (a)
        ADDR_CTRL:      rd = {30'h0, ctrl};
        ADDR_DSG_THR:   rd = {16'h0, dsg_thr};
        ADDR_CHG_THR:   rd = {16'h0, chg_thr};
        ADDR_QUIT_CUR:  rd = {16'h0, quit_cur};
        ADDR_DSG_RELAX: rd = {16'h0, dsg_relax_s};
        ADDR_CHG_RELAX: rd = {16'h0, chg_relax_s};
        ADDR_RESERVE:   rd = {16'h0, reserve_energy};
        ADDR_QPACK:     rd = {16'h0, qpack};
        ADDR_LEARN:     rd = {24'h0, learn_status_word};
        ADDR_STATUS:    rd = {26'h0, dvdt_ok, ocv_request, relax_mode, is_chg, is_dsg, dsg_flag};
        ADDR_AVG_I:     rd = {16'h0, avg_i_last};
        ADDR_AVG_P:     rd = avg_p_last;
        ADDR_SAG:       rd = {16'h0, peak_sag};
        ADDR_RES_EFF:   rd = {16'h0, reserve_comp};
        ADDR_SAG_PCT:   rd = {24'h0, sag_pct};
        ADDR_DVDT_LIM:  rd = {16'h0, dvdt_lim};
        default:        rd = '0;
      endcase
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) prdata <= '0;
    else if (clk_en && rd_acc && !penable) prdata <= rd;
  end
endmodule

// ### rcst_checker.sv
// Port checker for the state tracker and its bind
`timescale 1ns/10ps
module rcst_checker #(
  parameter int OCV_WAIT_CYCLES = 3,
  parameter int SEC_CYCLES      = 10
) (
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic [7:0] paddr,
  input wire logic       pready,
  input wire logic       pslverr,
  input wire logic       dsg_flag,
  input wire logic       relax_mode,
  input wire logic       ocv_request,
  input wire logic       qmax_update
);
  // ==========
  // Helpers
  // Free running second tick may cut the wait by up to one second
  localparam int WAIT_LO = (OCV_WAIT_CYCLES - 1) * SEC_CYCLES - 2;
  localparam int WAIT_HI = OCV_WAIT_CYCLES * SEC_CYCLES + 2;
  logic [15:0] relax_cnt;
  wire logic   mapped;
  assign mapped = (paddr <= 8'h50) && (paddr[1:0] == 2'b00);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) relax_cnt <= 16'h0000;
    else if (!relax_mode) relax_cnt <= 16'h0000;
    else if (!ocv_request) relax_cnt <= relax_cnt + 16'h0001;
  end
  // ==========
  // Assertions
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  a_reset_outputs: assert property ($rose(presetn) |-> dsg_flag && !relax_mode && !ocv_request)
    else $error("outputs wrong after reset");
  a_ready_always: assert property (psel |-> pready)
    else $error("pready low in a transfer");
  a_unmapped_err: assert property (psel && penable |-> pslverr == !mapped)
    else $error("pslverr disagrees with map");
  a_ocv_in_relax: assert property (ocv_request |-> relax_mode)
    else $error("ocv request outside relaxation");
  a_ocv_wait: assert property ($rose(ocv_request) |-> relax_cnt >= WAIT_LO && relax_cnt <= WAIT_HI)
    else $error("ocv request at wrong time");
  a_qmax_after_ocv: assert property (qmax_update |-> $past(ocv_request))
    else $error("capacity update without ocv request");
  a_qmax_spacing: assert property (qmax_update |=> !qmax_update [*8])
    else $error("capacity updates too close");
  a_relax_exit: assert property ($fell(relax_mode) |-> !ocv_request)
    else $error("ocv request kept after relaxation");
  c_relax: cover property ($rose(relax_mode));
  c_ocv: cover property ($rose(ocv_request));
  c_qmax: cover property (qmax_update);
endmodule
bind rcst_tracker rcst_checker #(.OCV_WAIT_CYCLES(OCV_WAIT_CYCLES), .SEC_CYCLES(SEC_CYCLES)) u_rcst_checker (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr), .pready(pready),
  .pslverr(pslverr), .dsg_flag(dsg_flag), .relax_mode(relax_mode), .ocv_request(ocv_request),
  .qmax_update(qmax_update));

// ### rcst_front_end.sv
// Measurement front end model with periodic current and voltage samples
`timescale 1ns/10ps
module rcst_front_end (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [15:0] cur_in,
  input  wire logic [15:0] volt_in,
  input  wire logic        ramp,
  output logic             sample_valid,
  output logic [15:0]      sample_current,
  output logic [15:0]      sample_voltage
);
  // ==========
  // Sample pacing
  logic [2:0]  phase;
  logic [15:0] v_ofs;
  wire logic   data_held;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase <= 3'h0;
      v_ofs <= 16'h0000;
    end else begin
      phase <= phase + 3'h1;
      if (ramp && phase == 3'h7) v_ofs <= v_ofs + 16'h0001;
    end
  end
  // Data inverted after hold, so a late capture cannot pass by luck
  assign data_held      = phase < 3'h6;
  assign sample_valid   = phase < 3'h4;
  assign sample_current = data_held ? cur_in : ~cur_in;
  assign sample_voltage = data_held ? volt_in + v_ofs : ~(volt_in + v_ofs);
endmodule

// ### rcst_tracker_tb.sv
// Self-checking testbench for the state tracker
`timescale 1ns/10ps
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin n_mismatch++; \
  $display("Error %0t: got %h exp %h", $time, (got), (exp)); end end
module rcst_tracker_tb;
  import rcst_pkg::*;
  // ==========
  // Signals
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic        soc_grid_point = 1'b0;
  logic [15:0] cur = 16'h0000;
  logic [15:0] volt = 16'h0fa0;
  logic        ramp = 1'b0;
  logic        clk_en = 1'b1;
  logic [1:0]  q_idx = 2'h3;
  logic [31:0] prdata, rd_data, s1;
  logic [15:0] sample_current, sample_voltage;
  logic        pready, pslverr, sample_valid, dsg_flag, relax_mode, ocv_request, qmax_update, rd_err, hi;
  int          n_mismatch = 0, compares = 0, cyc = 0, waited, i;
  logic [15:0] qv [4] = '{16'h0bb8, 16'h09c4, 16'h0af0, 16'h0b54};
  logic [15:0] tc [7] = '{16'h0096, 16'h0064, 16'h0001, 16'h0000, 16'hff9c, 16'hff9b, 16'h0065};
  logic [2:0]  ts [7] = '{3'b100, 3'b000, 3'b000, 3'b001, 3'b001, 3'b011, 3'b100};
  rcst_tracker #(.OCV_WAIT_CYCLES(3), .SEC_CYCLES(10)) u_rcst_tracker (
    .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sample_valid(sample_valid), .sample_current(sample_current), .sample_voltage(sample_voltage),
    .soc_grid_point(soc_grid_point), .cell_qmax_valid(1'b1), .cell_qmax_index(q_idx),
    .cell_qmax_value(16'h0800), .dsg_flag(dsg_flag), .relax_mode(relax_mode),
    .ocv_request(ocv_request), .qmax_update(qmax_update));
  rcst_front_end u_rcst_front_end (.pclk(pclk), .presetn(presetn), .cur_in(cur), .volt_in(volt),
    .ramp(ramp), .sample_valid(sample_valid), .sample_current(sample_current), .sample_voltage(sample_voltage));
  // ==========
  // Tasks
  always #10 pclk = ~pclk;
  task automatic summarize();
    if (n_mismatch == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 5000) begin
      n_mismatch++;
      summarize();
    end
  end
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd_data = prdata;
    rd_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic chk_rd(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] mask);
    apb(1'b0, a, 32'h0);
    `CHK(rd_data & mask, exp)
  endtask
  // Flag hi tells whether the chosen output went high within lim cycles
  task automatic wait_hi(input int sel, input int lim);
    hi = 1'b0;
    for (waited = 0; waited < lim && !hi; waited++) begin
      @(posedge pclk);
      hi = ((sel == 0) ? relax_mode : (sel == 1) ? ocv_request : qmax_update) === 1'b1;
    end
  endtask
  // ==========
  // Sequence
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    chk_rd(ADDR_CTRL, 32'h0, '1);
    chk_rd(ADDR_DSG_THR, 32'h0064, '1);
    chk_rd(ADDR_CHG_THR, {16'h0, CHG_THR_RST}, '1);
    chk_rd(ADDR_QUIT_CUR, {16'h0, QUIT_RST}, '1);
    chk_rd(ADDR_DSG_RELAX, {16'h0, RELAX_RST}, '1);
    chk_rd(ADDR_RESERVE, 32'h0, '1);
    chk_rd(ADDR_QPACK, {16'h0, QCELL_RST}, '1);
    chk_rd(ADDR_SAG_PCT, {24'h0, SAG_PCT_RST}, '1);
    chk_rd(ADDR_DVDT_LIM, 32'h4, '1);
    // A write with the clock enable low must not land
    clk_en <= 1'b0;
    apb(1'b1, ADDR_DSG_THR, 32'h0055);
    clk_en <= 1'b1;
    chk_rd(ADDR_DSG_THR, {16'h0, DSG_THR_RST}, '1);
    apb(1'b1, 8'h54, 32'hffff);
    `CHK(rd_err, 1'b1)
    chk_rd(8'h54, 32'h0, '1);
    `CHK(rd_err, 1'b1)
    apb(1'b1, ADDR_LEARN, 32'hff);
    chk_rd(ADDR_LEARN, 32'h6, '1);
    apb(1'b1, ADDR_LEARN, 32'h0);
    apb(1'b1, ADDR_MFG_CMD, 32'h0022);
    chk_rd(ADDR_LEARN, 32'h0, '1);
    apb(1'b1, ADDR_MFG_CMD, 32'h0021);
    chk_rd(ADDR_LEARN, 32'h4, '1);
    apb(1'b1, ADDR_RESERVE, 32'h0123);
    chk_rd(ADDR_RES_EFF, 32'h0, '1);
    apb(1'b1, ADDR_CTRL, 32'h1);
    chk_rd(ADDR_RES_EFF, 32'h0123, '1);
    apb(1'b1, ADDR_RESERVE, 32'h0);
    chk_rd(ADDR_RES_EFF, 32'h0, '1);
    for (i = 0; i < 4; i++) apb(1'b1, ADDR_QCELL0 + 8'(4 * i), {16'h0, qv[i]});
    chk_rd(ADDR_QPACK, 32'h09c4, '1);
    chk_rd(ADDR_QCELL0 + 8'h0c, 32'h0b54, '1);
    for (i = 0; i < 7; i++) begin
      cur <= tc[i];
      repeat (24) @(posedge pclk);
      chk_rd(ADDR_STATUS, {29'h0, ts[i]}, 32'h7);
      `CHK(dsg_flag, ts[i][0])
    end
    repeat (100) @(posedge pclk);
    volt <= 16'h0ed8;
    repeat (8) @(posedge pclk);
    volt <= 16'h0fa0;
    repeat (24) @(posedge pclk);
    apb(1'b0, ADDR_SAG, 32'h0);
    s1 = rd_data;
    `CHK(s1 != 32'h0, 1'b1)
    repeat (40) @(posedge pclk);
    chk_rd(ADDR_SAG, s1, '1);
    soc_grid_point <= 1'b1;
    repeat (8) @(posedge pclk);
    soc_grid_point <= 1'b0;
    chk_rd(ADDR_SAG, (s1 * SAG_PCT_RST) / 100, '1);
    // Quit band stays at its default, under both thresholds
    apb(1'b1, ADDR_DSG_RELAX, 32'h4);
    apb(1'b1, ADDR_CHG_RELAX, 32'h4);
    cur <= 16'hff38;
    repeat (40) @(posedge pclk);
    cur <= 16'h0000;
    repeat (8) @(posedge pclk);
    cur <= 16'hff38;
    wait_hi(0, 60);
    `CHK(hi, 1'b0)
    cur <= 16'h0000;
    wait_hi(0, 300);
    `CHK(hi && waited >= 30 && waited < 60, 1'b1)
    wait_hi(1, 300);
    `CHK(hi, 1'b1)
    wait_hi(2, 300);
    `CHK(hi, 1'b1)
    chk_rd(ADDR_QCELL0 + 8'h0c, 32'h0800, '1);
    chk_rd(ADDR_QPACK, 32'h0800, '1);
    chk_rd(ADDR_LEARN, 32'h2, 32'h2);
    apb(1'b0, ADDR_AVG_I, 32'h0);
    `CHK(rd_data, 32'h000000c8)
    apb(1'b0, ADDR_AVG_P, 32'h0);
    `CHK(rd_data, 32'h000c3500)
    apb(1'b1, ADDR_CTRL, 32'h3);
    apb(1'b1, ADDR_RESERVE, 32'h0100);
    chk_rd(ADDR_RES_EFF, 32'h00003600, '1);
    // Longer charge timer tells the two timers apart
    apb(1'b1, ADDR_CHG_RELAX, 32'h8);
    cur <= 16'h00c8;
    repeat (30) @(posedge pclk);
    `CHK(relax_mode, 1'b0)
    ramp <= 1'b1;
    cur <= 16'h0000;
    wait_hi(0, 300);
    `CHK(hi && waited >= 70, 1'b1)
    wait_hi(1, 300);
    `CHK(hi, 1'b1)
    wait_hi(2, 60);
    `CHK(hi, 1'b0)
    summarize();
  end
endmodule
